// ### include/kpm_map.vh
// register offsets, field positions and reset values of the host mailbox
`ifndef KPM_MAP_VH
`define KPM_MAP_VH

// firmware register offsets on the core port
`define KPM_OFF_IFACE_CTRL   4'h0
`define KPM_OFF_IRQ_CTRL     4'h1
`define KPM_OFF_KBD_STATUS   4'h2
`define KPM_OFF_KBD_DOUT     4'h3
`define KPM_OFF_MOUSE_DOUT   4'h4
`define KPM_OFF_KBD_DIN      4'h5
`define KPM_OFF_PM_STATUS    4'h6
`define KPM_OFF_PM_DOUT      4'h7
`define KPM_OFF_PM_DIN       4'h8

// host i/o addresses
`define KPM_HA_KBD_DATA      16'h0060
`define KPM_HA_PM_DATA       16'h0062
`define KPM_HA_KBD_CMD       16'h0064
`define KPM_HA_PM_CMD        16'h0066

// reset values
`define KPM_RST_IFACE_CTRL   8'h00
`define KPM_RST_IRQ_CTRL     8'h07
`define KPM_RST_STATUS       8'h00

// host_iface_control fields
`define KPM_CTL_KBD_HIE      0
`define KPM_CTL_MOUSE_HIE    1
`define KPM_CTL_KBD_OBE_CIE  2
`define KPM_CTL_KBD_IBF_CIE  3
`define KPM_CTL_PM_HIE       4
`define KPM_CTL_PM_OBE_CIE   5
`define KPM_CTL_PM_IBF_CIE   6
`define KPM_CTL_MASK         8'h7f

// host_irq_control fields
`define KPM_IRQ_MANUAL_LO    0
`define KPM_IRQ_MODE_LO      3
`define KPM_IRQ_MODE_HI      5
`define KPM_IRQ_INVERT       6
`define KPM_IRQ_PUSH_PULL    7

// channel status fields
`define KPM_ST_OBF           0
`define KPM_ST_IBF           1
`define KPM_ST_GP_FLAG       2
`define KPM_ST_ADDR_BIT      3
`define KPM_ST_FW_MASK       8'hf4

// pulse mode codes and widths in core clock cycles
`define KPM_MODE_LEVEL       3'h0
`define KPM_MODE_P1          3'h1
`define KPM_MODE_P2          3'h2
`define KPM_MODE_P4          3'h3
`define KPM_MODE_P8          3'h4
`define KPM_MODE_P16         3'h5
`define KPM_PULSE_W1         5'h01
`define KPM_PULSE_W2         5'h02
`define KPM_PULSE_W4         5'h04
`define KPM_PULSE_W8         5'h08
`define KPM_PULSE_W16        5'h10

`endif

// ### rtl/kpm_host_mailbox.v
// keyboard and power management host mailbox with host irq drivers
`timescale 1ns/100ps
`default_nettype none
`include "kpm_map.vh"

module kpm_host_mailbox #(
	parameter HOST_AW = 16,
	parameter NUM_IRQ = 3
) (
	input wire clk,
	input wire rst,
	input wire [3:0] core_addr,
	input wire core_wr,
	input wire core_rd,
	input wire [7:0] core_wdata,
	output wire [7:0] core_rdata,
	output wire kbd_out_empty_irq,
	output wire kbd_in_full_irq,
	output wire pm_out_empty_irq,
	output wire pm_in_full_irq,
	input wire [HOST_AW-1:0] host_addr,
	input wire host_rd_n,
	input wire host_wr_n,
	input wire [7:0] host_data_in,
	output wire [7:0] host_data_out,
	output wire host_data_oe,
	input wire [NUM_IRQ-1:0] host_irq_in,
	output wire [NUM_IRQ-1:0] host_irq_out,
	output wire [NUM_IRQ-1:0] host_irq_oe
);

	// firmware registers
	reg [7:0] host_iface_control_r;
	reg [7:0] host_irq_control_r;
	reg [7:0] kbd_status_r;
	reg [7:0] pm_status_r;
	reg [7:0] kbd_in_buf_r;
	reg [7:0] kbd_out_buf_r;
	reg [7:0] pm_in_buf_r;
	reg [7:0] pm_out_buf_r;
	reg mouse_src_r;
	reg [7:0] core_rdata_r;

	// host pin synchronisers
	reg [HOST_AW-1:0] haddr_s1_r;
	reg [HOST_AW-1:0] haddr_s2_r;
	reg [7:0] hdata_s1_r;
	reg [7:0] hdata_s2_r;
	reg [1:0] hstb_s1_r;
	reg [1:0] hstb_s2_r;
	reg [NUM_IRQ-1:0] irq_s1_r;
	reg [NUM_IRQ-1:0] irq_s2_r;
	reg wr_act_d_r;
	reg rd_act_d_r;
	reg [HOST_AW-1:0] rd_addr_r;
	reg [7:0] host_data_out_r;
	reg host_data_oe_r;

	// decoded firmware accesses
	wire fw_wr_ctl = core_wr && (core_addr == `KPM_OFF_IFACE_CTRL);
	wire fw_wr_irq = core_wr && (core_addr == `KPM_OFF_IRQ_CTRL);
	wire fw_wr_kst = core_wr && (core_addr == `KPM_OFF_KBD_STATUS);
	wire fw_wr_pst = core_wr && (core_addr == `KPM_OFF_PM_STATUS);
	wire fw_wr_kdo = core_wr && (core_addr == `KPM_OFF_KBD_DOUT);
	wire fw_wr_mdo = core_wr && (core_addr == `KPM_OFF_MOUSE_DOUT);
	wire fw_wr_pdo = core_wr && (core_addr == `KPM_OFF_PM_DOUT);
	wire fw_rd_kdi = core_rd && (core_addr == `KPM_OFF_KBD_DIN);
	wire fw_rd_pdi = core_rd && (core_addr == `KPM_OFF_PM_DIN);

	// host strobe edges, seen after two flip-flops
	wire wr_act = ~hstb_s2_r[1];
	wire rd_act = ~hstb_s2_r[0];
	wire wr_start = wr_act && !wr_act_d_r;
	wire rd_end = rd_act_d_r && !rd_act;
	wire [HOST_AW-1:0] ha_kd = `KPM_HA_KBD_DATA;
	wire [HOST_AW-1:0] ha_kc = `KPM_HA_KBD_CMD;
	wire [HOST_AW-1:0] ha_pd = `KPM_HA_PM_DATA;
	wire [HOST_AW-1:0] ha_pc = `KPM_HA_PM_CMD;
	wire h_kbd_hit = (haddr_s2_r == ha_kd) || (haddr_s2_r == ha_kc);
	wire h_pm_hit = (haddr_s2_r == ha_pd) || (haddr_s2_r == ha_pc);
	wire h_wr_kbd = wr_start && h_kbd_hit;
	wire h_wr_pm = wr_start && h_pm_hit;
	wire h_rd_kdata = rd_end && (rd_addr_r == ha_kd);
	wire h_rd_pdata = rd_end && (rd_addr_r == ha_pd);

	// control fields
	wire [2:0] irq_mode = host_irq_control_r[`KPM_IRQ_MODE_HI:`KPM_IRQ_MODE_LO];
	wire irq_invert = host_irq_control_r[`KPM_IRQ_INVERT];
	wire irq_push_pull_enable = host_irq_control_r[`KPM_IRQ_PUSH_PULL];
	wire [NUM_IRQ-1:0] irq_manual = host_irq_control_r[`KPM_IRQ_MANUAL_LO +: NUM_IRQ];
	wire kbd_host_irq_enable = host_iface_control_r[`KPM_CTL_KBD_HIE];
	wire mouse_host_irq_enable = host_iface_control_r[`KPM_CTL_MOUSE_HIE];
	wire pm_host_irq_enable = host_iface_control_r[`KPM_CTL_PM_HIE];
	wire kbd_out_empty_core_ie = host_iface_control_r[`KPM_CTL_KBD_OBE_CIE];
	wire kbd_in_full_core_ie = host_iface_control_r[`KPM_CTL_KBD_IBF_CIE];
	wire pm_out_empty_core_ie = host_iface_control_r[`KPM_CTL_PM_OBE_CIE];
	wire pm_in_full_core_ie = host_iface_control_r[`KPM_CTL_PM_IBF_CIE];
	wire kbd_obf = kbd_status_r[`KPM_ST_OBF];
	wire kbd_ibf = kbd_status_r[`KPM_ST_IBF];
	wire pm_obf = pm_status_r[`KPM_ST_OBF];
	wire pm_ibf = pm_status_r[`KPM_ST_IBF];

	// per-line hardware enables, level sources and triggers
	wire [NUM_IRQ-1:0] hw_en = {pm_host_irq_enable, mouse_host_irq_enable, kbd_host_irq_enable};
	wire [NUM_IRQ-1:0] lvl_src = {pm_obf, kbd_obf & mouse_src_r, kbd_obf & ~mouse_src_r};
	wire [NUM_IRQ-1:0] trig = {fw_wr_pdo, fw_wr_mdo, fw_wr_kdo};

	// pulse width for the current mode, zero for level and reserved codes
	function [4:0] pulse_width;
		input [2:0] mode;
		begin
			case (mode)
				`KPM_MODE_P1: pulse_width = `KPM_PULSE_W1;
				`KPM_MODE_P2: pulse_width = `KPM_PULSE_W2;
				`KPM_MODE_P4: pulse_width = `KPM_PULSE_W4;
				`KPM_MODE_P8: pulse_width = `KPM_PULSE_W8;
				`KPM_MODE_P16: pulse_width = `KPM_PULSE_W16;
				default: pulse_width = 5'h00;
			endcase
		end
	endfunction

	wire pulse_mode = (irq_mode != `KPM_MODE_LEVEL);
	wire [4:0] cur_width = pulse_width(irq_mode);

	// host pins pass two flip-flops before any use
	// the strobes reset to their released level, so that no false
	// host access is seen in the first cycles after reset.
	// the irq readback flops reset to the pulled-up level, which is
	// what the pins show while the reset control byte holds every
	// line released; otherwise an early firmware read of the manual
	// bits would report low lines that are in fact high.
	// address and data need no special value, they are only used
	// while a synced strobe is active.
	// a host that changes address and strobe together may see one
	// cycle of mixed address bits; the host must set the address
	// some cycles ahead of the strobe.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			haddr_s1_r <= {HOST_AW{1'b0}};
			haddr_s2_r <= {HOST_AW{1'b0}};
			hdata_s1_r <= 8'h00;
			hdata_s2_r <= 8'h00;
			hstb_s1_r <= 2'h3;
			hstb_s2_r <= 2'h3;
			irq_s1_r <= {NUM_IRQ{1'b1}}; // released lines read high
			irq_s2_r <= {NUM_IRQ{1'b1}};
		end else begin
			haddr_s1_r <= host_addr;
			haddr_s2_r <= haddr_s1_r;
			hdata_s1_r <= host_data_in;
			hdata_s2_r <= hdata_s1_r;
			hstb_s1_r <= {host_wr_n, host_rd_n};
			hstb_s2_r <= hstb_s1_r;
			irq_s1_r <= host_irq_in;
			irq_s2_r <= irq_s1_r;
		end
	end

	// strobe history and host read address hold
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_act_d_r <= 1'b0;
			rd_act_d_r <= 1'b0;
			rd_addr_r <= {HOST_AW{1'b0}};
		end else begin
			wr_act_d_r <= wr_act;
			rd_act_d_r <= rd_act;
			if (rd_act) begin
				rd_addr_r <= haddr_s2_r;
			end
		end
	end

	// host read data mux, registered onto the data pins
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			host_data_out_r <= 8'h00;
			host_data_oe_r <= 1'b0;
		end else begin
			host_data_oe_r <= rd_act && (h_kbd_hit || h_pm_hit);
			if (haddr_s2_r == ha_kd) begin
				host_data_out_r <= kbd_out_buf_r;
			end else if (haddr_s2_r == ha_kc) begin
				host_data_out_r <= kbd_status_r;
			end else if (haddr_s2_r == ha_pd) begin
				host_data_out_r <= pm_out_buf_r;
			end else if (haddr_s2_r == ha_pc) begin
				host_data_out_r <= pm_status_r;
			end else begin
				host_data_out_r <= 8'h00;
			end
		end
	end

	// firmware control registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			host_iface_control_r <= `KPM_RST_IFACE_CTRL;
			host_irq_control_r <= `KPM_RST_IRQ_CTRL;
		end else begin
			if (fw_wr_ctl) begin
				host_iface_control_r <= core_wdata & `KPM_CTL_MASK;
			end
			if (fw_wr_irq) begin
				host_irq_control_r <= core_wdata;
			end
		end
	end

	// keyboard channel buffers and status
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			kbd_status_r <= `KPM_RST_STATUS;
			kbd_in_buf_r <= 8'h00;
			kbd_out_buf_r <= 8'h00;
			mouse_src_r <= 1'b0;
		end else begin
			if (fw_wr_kst) begin
				// only the firmware flags take the write
				kbd_status_r[7:4] <= core_wdata[7:4];
				kbd_status_r[`KPM_ST_GP_FLAG] <= core_wdata[`KPM_ST_GP_FLAG];
			end
			if (fw_wr_kdo || fw_wr_mdo) begin
				kbd_out_buf_r <= core_wdata;
				mouse_src_r <= fw_wr_mdo;
				kbd_status_r[`KPM_ST_OBF] <= 1'b1;
			end else if (h_rd_kdata) begin
				kbd_status_r[`KPM_ST_OBF] <= 1'b0;
			end
			if (h_wr_kbd) begin
				kbd_in_buf_r <= hdata_s2_r;
				kbd_status_r[`KPM_ST_IBF] <= 1'b1;
				kbd_status_r[`KPM_ST_ADDR_BIT] <= haddr_s2_r[2];
			end else if (fw_rd_kdi) begin
				kbd_status_r[`KPM_ST_IBF] <= 1'b0;
			end
		end
	end

	// pm channel buffers and status
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pm_status_r <= `KPM_RST_STATUS;
			pm_in_buf_r <= 8'h00;
			pm_out_buf_r <= 8'h00;
		end else begin
			if (fw_wr_pst) begin
				pm_status_r[7:4] <= core_wdata[7:4];
				pm_status_r[`KPM_ST_GP_FLAG] <= core_wdata[`KPM_ST_GP_FLAG];
			end
			if (fw_wr_pdo) begin
				pm_out_buf_r <= core_wdata;
				pm_status_r[`KPM_ST_OBF] <= 1'b1;
			end else if (h_rd_pdata) begin
				pm_status_r[`KPM_ST_OBF] <= 1'b0;
			end
			if (h_wr_pm) begin
				pm_in_buf_r <= hdata_s2_r;
				pm_status_r[`KPM_ST_IBF] <= 1'b1;
				pm_status_r[`KPM_ST_ADDR_BIT] <= haddr_s2_r[2];
			end else if (fw_rd_pdi) begin
				pm_status_r[`KPM_ST_IBF] <= 1'b0;
			end
		end
	end

	// firmware read data, valid the cycle after core_rd
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			core_rdata_r <= 8'h00;
		end else if (core_rd) begin
			case (core_addr)
				`KPM_OFF_IFACE_CTRL: core_rdata_r <= host_iface_control_r;
				// manual bits read back the synced pin level
				`KPM_OFF_IRQ_CTRL: core_rdata_r <= {host_irq_control_r[7:NUM_IRQ], irq_s2_r};
				`KPM_OFF_KBD_STATUS: core_rdata_r <= kbd_status_r;
				`KPM_OFF_KBD_DIN: core_rdata_r <= kbd_in_buf_r;
				`KPM_OFF_PM_STATUS: core_rdata_r <= pm_status_r;
				`KPM_OFF_PM_DIN: core_rdata_r <= pm_in_buf_r;
				default: core_rdata_r <= 8'h00;
			endcase
		end
	end

	// core interrupts follow the buffer flags, gated by their enables
	assign kbd_out_empty_irq = kbd_out_empty_core_ie & ~kbd_obf;
	assign kbd_in_full_irq = kbd_in_full_core_ie & kbd_ibf;
	assign pm_out_empty_irq = pm_out_empty_core_ie & ~pm_obf;
	assign pm_in_full_irq = pm_in_full_core_ie & pm_ibf;

	// one pulse counter and pin driver per host irq line
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi = gi + 1) begin : g_irq
			reg [4:0] pulse_cnt_r;
			reg [4:0] pulse_cnt_nxt;
			reg line_lvl;

			// counter loads on the write, so the pulse starts one cycle later
			always @* begin
				pulse_cnt_nxt = pulse_cnt_r;
				if (trig[gi] && hw_en[gi] && pulse_mode) begin
					pulse_cnt_nxt = cur_width;
				end else if (pulse_cnt_r != 5'h00) begin
					pulse_cnt_nxt = pulse_cnt_r - 5'h01;
				end
			end

			always @(posedge clk or posedge rst) begin
				if (rst) begin
					pulse_cnt_r <= 5'h00;
				end else begin
					pulse_cnt_r <= pulse_cnt_nxt;
				end
			end

			// logic level before the pin driver
			always @* begin
				line_lvl = irq_manual[gi];
				if (!hw_en[gi]) begin
					line_lvl = irq_manual[gi];
				end else if (!pulse_mode) begin
					line_lvl = lvl_src[gi] ^ irq_invert;
				end else begin
					line_lvl = (pulse_cnt_r == 5'h00) ^ irq_invert;
				end
			end

			// open drain drives only low, push pull drives both levels
			assign host_irq_out[gi] = line_lvl;
			assign host_irq_oe[gi] = irq_push_pull_enable | ~line_lvl;
		end
	endgenerate

	assign core_rdata = core_rdata_r;
	assign host_data_out = host_data_out_r;
	assign host_data_oe = host_data_oe_r;

endmodule // kpm_host_mailbox

`default_nettype wire

// ### bench/kpm_mailbox_monitor.sv
// assertion checker on the host mailbox ports
`timescale 1ns/100ps
`default_nettype none
module kpm_mailbox_monitor #(
	parameter NUM_IRQ = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] core_addr,
	input wire logic core_wr,
	input wire logic core_rd,
	input wire logic [7:0] core_rdata,
	input wire logic kbd_out_empty_irq,
	input wire logic kbd_in_full_irq,
	input wire logic pm_out_empty_irq,
	input wire logic pm_in_full_irq,
	input wire logic host_rd_n,
	input wire logic host_data_oe,
	input wire logic [NUM_IRQ-1:0] host_irq_out,
	input wire logic [NUM_IRQ-1:0] host_irq_oe
);
	// one clock domain, reset disables every check
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// data-out writes and data-in reads drop the core interrupts
	AST_KDO: assert property (core_wr && core_addr == 4'h3 |=> !kbd_out_empty_irq)
		else $error("kbd empty irq after write");
	AST_MDO: assert property (core_wr && core_addr == 4'h4 |=> !kbd_out_empty_irq)
		else $error("kbd empty irq after mouse write");
	AST_PDO: assert property (core_wr && core_addr == 4'h7 |=> !pm_out_empty_irq)
		else $error("pm empty irq after write");
	AST_KDI: assert property (core_rd && core_addr == 4'h5 |=> !kbd_in_full_irq)
		else $error("kbd full irq after read");
	AST_PDI: assert property (core_rd && core_addr == 4'h8 |=> !pm_in_full_irq)
		else $error("pm full irq after read");
	// read data holds between reads
	AST_RDATA: assert property (!core_rd && !$past(core_rd) |=> $stable(core_rdata))
		else $error("read data moved");
	// irq drivers and their reset state
	AST_OD: assert property (host_irq_oe == '1 || host_irq_oe == ~host_irq_out)
		else $error("irq driven high in open drain");
	AST_RST: assert property ($fell(rst) |-> host_irq_out == '1 && host_irq_oe == '0)
		else $error("irq lines wrong after reset");
	// host data bus only driven around a read strobe
	AST_HDRV: assert property ($rose(host_data_oe) |-> !$past(host_rd_n, 2))
		else $error("host bus driven without read");
	AST_HREL: assert property (host_rd_n [*5] |-> !host_data_oe)
		else $error("host bus held after read");
	// main scenarios reached
	cover property ($fell(host_irq_out[0]));
	cover property ($rose(host_data_oe));
	cover property ($rose(pm_in_full_irq));
endmodule // kpm_mailbox_monitor
`default_nettype wire

// ### bench/kpm_host_model.sv
// host side model: i/o cycles and pulled-up irq lines
`timescale 1ns/100ps
`default_nettype none
module kpm_host_model (
	input wire logic clk,
	output logic [15:0] host_addr,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic [2:0] irq_out,
	input wire logic [2:0] irq_oe,
	output wire logic [2:0] irq_pin
);
	logic busy = 1'b0;
	// released open-drain lines float up to the pull-up
	assign irq_pin = irq_out | ~irq_oe;
	// strobes idle high, a released data bus keeps changing
	initial begin
		host_addr = 16'h0000;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_data_in = 8'h00;
	end
	always @(negedge clk) if (!busy) host_data_in <= ~host_data_in;
	// read cycle, data taken while the device drives it
	task automatic hrd(input logic [15:0] a, output logic [7:0] d);
		busy = 1'b1;
		@(negedge clk);
		host_addr = a;
		repeat (3) @(negedge clk);
		host_rd_n = 1'b0;
		repeat (5) @(negedge clk);
		d = host_data_oe ? host_data_out : 8'hxx;
		host_rd_n = 1'b1;
		repeat (4) @(negedge clk);
		busy = 1'b0;
	endtask
	// write cycle, preceded by a status read to see the input flag
	task automatic hwr(input logic [15:0] a, input logic [7:0] v, output logic [7:0] st);
		hrd(a | 16'h0004, st);
		busy = 1'b1;
		@(negedge clk);
		host_addr = a;
		host_data_in = v;
		repeat (3) @(negedge clk);
		host_wr_n = 1'b0;
		repeat (4) @(negedge clk);
		host_wr_n = 1'b1;
		repeat (4) @(negedge clk);
		busy = 1'b0;
	endtask
endmodule // kpm_host_model
`default_nettype wire

// ### bench/kpm_host_mailbox_bench.sv
// random and corner-case bench for the host mailbox
`timescale 1ns/100ps
`default_nettype none
`include "kpm_map.vh"
module kpm_host_mailbox_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] core_addr = 4'h0;
	logic core_wr = 1'b0;
	logic core_rd = 1'b0;
	logic [7:0] core_wdata = 8'h00;
	wire logic [7:0] core_rdata, host_data_out, host_data_in;
	wire logic koe, kif, poe, pif, host_rd_n, host_wr_n, host_data_oe;
	wire logic [15:0] host_addr;
	wire logic [2:0] irq_out, irq_oe, irq_pin;
	logic [7:0] fw [2];
	logic [1:0] output_full_flag = 2'h0, input_full_flag = 2'h0, a2 = 2'h0;
	logic [7:0] lf = 8'h1b, d, st, v, g;
	logic [2:0] m;
	logic inv, lvl;
	int fails = 0, comparisons = 0, n, c;
	// 20 MHz core clock
	always #25 clk = ~clk;
	// device and host model
	kpm_host_mailbox #(.HOST_AW(16), .NUM_IRQ(3)) u_dut (.clk(clk), .rst(rst), .core_addr(core_addr),
		.core_wr(core_wr), .core_rd(core_rd), .core_wdata(core_wdata), .core_rdata(core_rdata),
		.kbd_out_empty_irq(koe), .kbd_in_full_irq(kif), .pm_out_empty_irq(poe), .pm_in_full_irq(pif),
		.host_addr(host_addr), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_irq_in(irq_pin),
		.host_irq_out(irq_out), .host_irq_oe(irq_oe));
	kpm_host_model u_host (.clk(clk), .host_addr(host_addr), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.irq_out(irq_out), .irq_oe(irq_oe), .irq_pin(irq_pin));
	// stimulus shift register, expected status and pulse width
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] stat(input int ch);
		return {fw[ch][7:4], a2[ch], fw[ch][2], input_full_flag[ch], output_full_flag[ch]};
	endfunction
	function automatic int wid(input logic [2:0] md);
		return (md >= 3'h1 && md <= 3'h5) ? 1 << (md - 3'h1) : 0;
	endfunction
	// byte compare with counting
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// firmware register write and read
	task automatic cwr(input logic [3:0] a, input logic [7:0] w);
		@(negedge clk);
		core_addr = a;
		core_wdata = w;
		core_wr = 1'b1;
		@(negedge clk);
		core_wr = 1'b0;
	endtask
	task automatic crd(input logic [3:0] a, output logic [7:0] r);
		@(negedge clk);
		core_addr = a;
		core_rd = 1'b1;
		@(negedge clk);
		core_rd = 1'b0;
		@(negedge clk);
		r = core_rdata;
	endtask
	// verdict and end of run
	task automatic end_of_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// cut a hang short
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		end_of_test;
	end
	// reset, manual lines, host writes, then every irq mode
	initial begin
		fw[0] = 8'h00;
		fw[1] = 8'h00;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		crd(`KPM_OFF_IRQ_CTRL, d);
		chk(d, `KPM_RST_IRQ_CTRL);
		chk({5'h00, irq_oe}, 8'h00);
		crd(4'hf, d);
		chk(d, 8'h00);
		cwr(`KPM_OFF_IRQ_CTRL, 8'h85);
		chk({2'h0, irq_oe, irq_pin}, 8'h3d);
		repeat (2) @(negedge clk);
		crd(`KPM_OFF_IRQ_CTRL, d);
		chk(d, 8'h85);
		cwr(`KPM_OFF_IRQ_CTRL, 8'h02);
		chk({2'h0, irq_oe, irq_pin}, 8'h2a);
		repeat (2) @(negedge clk);
		crd(`KPM_OFF_IRQ_CTRL, d);
		chk(d, 8'h02);
		cwr(`KPM_OFF_IFACE_CTRL, 8'h6c);
		chk({6'h00, poe, koe}, 8'h03);
		for (int i = 0; i < 4; i++) begin
			c = i % 2;
			lf = nx(lf);
			fw[c] = lf;
			cwr(c ? `KPM_OFF_PM_STATUS : `KPM_OFF_KBD_STATUS, lf);
			crd(c ? `KPM_OFF_PM_STATUS : `KPM_OFF_KBD_STATUS, d);
			chk(d, stat(c));
			v = nx(lf);
			u_host.hwr(16'h0060 + 16'(2 * i), v, st);
			chk(st, stat(c));
			input_full_flag[c] = 1'b1;
			a2[c] = i[1];
			crd(c ? `KPM_OFF_PM_STATUS : `KPM_OFF_KBD_STATUS, d);
			chk(d, stat(c));
			chk({6'h00, pif, kif}, {6'h00, input_full_flag});
			crd(c ? `KPM_OFF_PM_DIN : `KPM_OFF_KBD_DIN, d);
			input_full_flag[c] = 1'b0;
			chk(d, v);
			chk({6'h00, pif, kif}, 8'h00);
		end
		cwr(`KPM_OFF_IFACE_CTRL, 8'h77);
		for (int j = 0; j < 48; j++) begin
			c = (j % 3 == 2);
			{inv, m} = 4'(j / 3);
			lf = nx(lf);
			lvl = (m == 3'h0) ^ inv;
			cwr(`KPM_OFF_IRQ_CTRL, {lf[7], inv, m, 3'h0});
			cwr(j % 3 == 0 ? `KPM_OFF_KBD_DOUT : j % 3 == 1 ? `KPM_OFF_MOUSE_DOUT : `KPM_OFF_PM_DOUT, lf);
			output_full_flag[c] = 1'b1;
			chk({6'h00, poe, koe}, {6'h00, ~output_full_flag});
			n = 0;
			repeat (20) begin
				n += (irq_pin[j % 3] === lvl);
				@(negedge clk);
			end
			g = m == 3'h0 ? {7'h00, irq_pin[j % 3]} : 8'(n);
			chk(g, m == 3'h0 ? {7'h00, lvl} : 8'(wid(m)));
			u_host.hrd(c ? 16'h0062 : 16'h0060, d);
			output_full_flag[c] = 1'b0;
			chk(d, lf);
			chk({5'h00, poe, koe, irq_pin[j % 3]}, {5'h00, ~output_full_flag, ~lvl});
		end
		end_of_test;
	end
endmodule // kpm_host_mailbox_bench
// checker on the device ports
bind kpm_host_mailbox kpm_mailbox_monitor #(.NUM_IRQ(NUM_IRQ)) u_mon (.clk(clk), .rst(rst),
	.core_addr(core_addr), .core_wr(core_wr), .core_rd(core_rd), .core_rdata(core_rdata),
	.kbd_out_empty_irq(kbd_out_empty_irq), .kbd_in_full_irq(kbd_in_full_irq),
	.pm_out_empty_irq(pm_out_empty_irq), .pm_in_full_irq(pm_in_full_irq), .host_rd_n(host_rd_n),
	.host_data_oe(host_data_oe), .host_irq_out(host_irq_out), .host_irq_oe(host_irq_oe));
`default_nettype wire
